/* File: acu_cfg.svh */
// constants for the accumulator xor and compare unit
`ifndef ACU_CFG_SVH
`define ACU_CFG_SVH
`define ACU_ACC_W 32
`define ACU_WORD_W 16
`define ACU_CNT_W 6
`define ACU_CNT_MIN 6'd1
`define ACU_CNT_MAX 6'd32
`define ACU_ACC_RST 32'h0000_0000
`define ACU_MSB 31
`define ACU_HI_ZERO 16'h0000
`endif

/* File: acu_pkg.sv */
// types for the accumulator xor and compare unit
package acu_pkg;
   typedef enum logic [1:0] {
      acu_xor_double_op,
      acu_xor_formatted_op,
      acu_compare_word_op,
      acu_compare_double_op
   } acu_op_e;
   typedef enum logic [2:0] {
      acu_space_input,
      acu_space_output,
      acu_space_control_relay,
      acu_space_stage,
      acu_space_timer,
      acu_space_counter,
      acu_space_special_relay
   } acu_space_e;
endpackage

/* File: acu_magnitude_cmp.sv */
// unsigned magnitude comparator
`timescale 1ns/1ns
module acu_magnitude_cmp #(
   parameter int WIDTH = 32
) (
   input wire logic [WIDTH-1:0] lhs_in,
   input wire logic [WIDTH-1:0] rhs_in,
   output logic less_out,
   output logic equal_out,
   output logic greater_out
);
   initial begin
      if (WIDTH < 1) begin
         $error("acu_magnitude_cmp: WIDTH must be at least 1");
      end
   end
   assign less_out = lhs_in < rhs_in;
   assign equal_out = lhs_in == rhs_in;
   assign greater_out = lhs_in > rhs_in;
endmodule

/* File: acu_xor_compare_unit.sv */
// accumulator xor and compare unit
//
// Contract
// - a double xor replaces the whole 32-bit accumulator with accumulator xor operand.
// - the double xor operand is an immediate of up to eight hex digits, not a memory word.
// - after a double xor, zero flag is result==0 and negative flag is result msb.
// - a formatted xor xors a run of 1 to 32 gathered bits into the low accumulator bits.
// - after a formatted xor, zero flag is result==0 and negative flag is result msb.
// - a formatted xor accepts the seven listed bit spaces and an immediate bit count.
// - a word compare checks the low 16 accumulator bits against one memory word only.
// - after any compare exactly one of less, equal and greater is set.
// - a double compare checks all 32 bits against two memory words or an immediate.
// - flags change when an instruction ends and hold until one writing them runs.
`timescale 1ns/1ns
`include "acu_cfg.svh"
module acu_xor_compare_unit #(
   parameter int ACC_W = `ACU_ACC_W,
   parameter int WORD_W = `ACU_WORD_W
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic acc_load_in,
   input wire logic [ACC_W-1:0] acc_load_data_in,
   input wire logic op_valid_in,
   input wire acu_pkg::acu_op_e op_code_in,
   input wire logic use_imm_in,
   input wire logic [ACC_W-1:0] imm_in,
   input wire logic [WORD_W-1:0] mem_word_lo_in,
   input wire logic [WORD_W-1:0] mem_word_hi_in,
   input wire logic [2:0] bit_space_in,
   input wire logic [`ACU_CNT_W-1:0] bit_count_in,
   input wire logic [ACC_W-1:0] bit_run_in,
   output logic [ACC_W-1:0] acc_out,
   output logic zero_result_flag_out,
   output logic negative_result_flag_out,
   output logic less_than_flag_out,
   output logic equal_flag_out,
   output logic greater_than_flag_out,
   output logic done_out,
   output logic reject_out
);
   import acu_pkg::*;

   initial begin
      if (ACC_W != 2 * WORD_W || ACC_W != `ACU_ACC_W) begin
         $error("acu_xor_compare_unit: ACC_W must be 32 and twice WORD_W");
      end
   end

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   function automatic logic [ACC_W-1:0] run_mask(input logic [`ACU_CNT_W-1:0] cnt);
      logic [ACC_W-1:0] one;
      one = {{(ACC_W-1){1'b0}}, 1'b1};
      if (cnt >= `ACU_CNT_MAX) begin
         run_mask = '1;
      end else begin
         run_mask = (one << cnt) - one;
      end
   endfunction

   wire is_xd = op_valid_in && op_code_in == acu_xor_double_op;
   wire is_xf = op_valid_in && op_code_in == acu_xor_formatted_op;
   wire is_cw = op_valid_in && op_code_in == acu_compare_word_op;
   wire is_cd = op_valid_in && op_code_in == acu_compare_double_op;
   // formatted run must name a listed space and a count of 1 to 32
   wire space_ok = bit_space_in <= 3'(acu_space_special_relay);
   wire count_ok = bit_count_in >= `ACU_CNT_MIN && bit_count_in <= `ACU_CNT_MAX;
   wire fmt_ok = space_ok && count_ok;
   wire xf_go = is_xf && fmt_ok;
   wire xf_bad = is_xf && !fmt_ok;
   wire xor_go = is_xd || xf_go;
   wire cmp_go = is_cw || is_cd;

   // ---------------------------------------------
   // datapath
   // ---------------------------------------------
   logic [ACC_W-1:0] acc;
   logic zero_flag;
   logic neg_flag;
   logic lt_flag;
   logic eq_flag;
   logic gt_flag;
   logic done;
   logic reject;

   wire [ACC_W-1:0] xd_result = acc ^ imm_in;
   wire [ACC_W-1:0] xf_result = acc ^ (bit_run_in & run_mask(bit_count_in));
   wire [ACC_W-1:0] xor_result = is_xd ? xd_result : xf_result;
   wire [ACC_W-1:0] dbl_operand = use_imm_in ? imm_in : {mem_word_hi_in, mem_word_lo_in};
   wire [ACC_W-1:0] cmp_lhs = is_cw ? {`ACU_HI_ZERO, acc[WORD_W-1:0]} : acc;
   wire [ACC_W-1:0] cmp_rhs = is_cw ? {`ACU_HI_ZERO, mem_word_lo_in} : dbl_operand;
   wire cmp_lt;
   wire cmp_eq;
   wire cmp_gt;

   acu_magnitude_cmp #(
      .WIDTH(ACC_W)
   ) u_cmp (
      .lhs_in(cmp_lhs),
      .rhs_in(cmp_rhs),
      .less_out(cmp_lt),
      .equal_out(cmp_eq),
      .greater_out(cmp_gt)
   );

   wire [ACC_W-1:0] next_acc = xor_go ? xor_result : (acc_load_in ? acc_load_data_in : acc);
   wire next_zero = xor_go ? (xor_result == '0) : zero_flag;
   wire next_neg = xor_go ? xor_result[`ACU_MSB] : neg_flag;
   wire next_lt = cmp_go ? cmp_lt : lt_flag;
   wire next_eq = cmp_go ? cmp_eq : eq_flag;
   wire next_gt = cmp_go ? cmp_gt : gt_flag;

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         acc <= `ACU_ACC_RST;
         zero_flag <= 1'b0;
         neg_flag <= 1'b0;
         lt_flag <= 1'b0;
         eq_flag <= 1'b0;
         gt_flag <= 1'b0;
         done <= 1'b0;
         reject <= 1'b0;
      end else begin
         acc <= next_acc;
         zero_flag <= next_zero;
         neg_flag <= next_neg;
         lt_flag <= next_lt;
         eq_flag <= next_eq;
         gt_flag <= next_gt;
         done <= xor_go || cmp_go;
         reject <= xf_bad;
      end
   end

   assign acc_out = acc;
   assign zero_result_flag_out = zero_flag;
   assign negative_result_flag_out = neg_flag;
   assign less_than_flag_out = lt_flag;
   assign equal_flag_out = eq_flag;
   assign greater_than_flag_out = gt_flag;
   assign done_out = done;
   assign reject_out = reject;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);

   wire [ACC_W-1:0] chk_xd = acc_out ^ imm_in;
   wire [ACC_W-1:0] chk_fmask = (bit_count_in == `ACU_CNT_MAX) ? '1 :
      ~({ACC_W{1'b1}} << bit_count_in);
   wire [ACC_W-1:0] chk_xf = acc_out ^ (bit_run_in & chk_fmask);
   wire chk_wlt = acc_out[WORD_W-1:0] < mem_word_lo_in;
   wire chk_dgt = acc_out > (use_imm_in ? imm_in : {mem_word_hi_in, mem_word_lo_in});
   wire any_op = op_valid_in;
   wire chk_weq = acc_out[WORD_W-1:0] == mem_word_lo_in;
   wire chk_wgt = acc_out[WORD_W-1:0] > mem_word_lo_in;
   wire [ACC_W-1:0] chk_dop = use_imm_in ? imm_in : {mem_word_hi_in, mem_word_lo_in};
   wire chk_dlt = acc_out < chk_dop;
   wire chk_deq = acc_out == chk_dop;

   a_xor_double_acc: assert property (is_xd |=> acc_out == $past(chk_xd))
      else $error("double xor result wrong");
   a_xor_double_imm: assert property (is_xd |=>
      (acc_out ^ $past(acc_out)) == $past(imm_in))
      else $error("double xor did not use the immediate");
   a_xor_double_flags: assert property (is_xd |=> done_out &&
      zero_result_flag_out == (acc_out == '0) &&
      negative_result_flag_out == acc_out[`ACU_MSB])
      else $error("double xor flags wrong");
   a_xor_fmt_acc: assert property (xf_go |=> acc_out == $past(chk_xf))
      else $error("formatted xor result wrong");
   a_xor_fmt_flags: assert property (xf_go |=>
      zero_result_flag_out == (acc_out == '0) &&
      negative_result_flag_out == acc_out[`ACU_MSB])
      else $error("formatted xor flags wrong");
   a_fmt_bad_run: assert property (xf_bad && !acc_load_in |=>
      reject_out && !done_out && $stable(acc_out) && $stable(zero_result_flag_out))
      else $error("bad formatted run not refused");
   a_fmt_bad_keep: assert property (xf_bad |=> $stable({negative_result_flag_out,
      less_than_flag_out, equal_flag_out, greater_than_flag_out}))
      else $error("bad formatted run changed flags");
   a_cmp_word_low: assert property (is_cw && !acc_load_in |=>
      $stable(acc_out) && less_than_flag_out == $past(chk_wlt))
      else $error("word compare wrong or changed accumulator");
   a_cmp_word_eq: assert property (is_cw |=>
      equal_flag_out == $past(chk_weq) && greater_than_flag_out == $past(chk_wgt))
      else $error("word compare equal or greater wrong");
   a_cmp_one_hot: assert property (cmp_go |=> $onehot({less_than_flag_out,
      equal_flag_out, greater_than_flag_out}))
      else $error("compare flags not one-hot");
   a_cmp_double_val: assert property (is_cd |=>
      greater_than_flag_out == $past(chk_dgt))
      else $error("double compare wrong");
   a_cmp_double_eq: assert property (is_cd |=>
      less_than_flag_out == $past(chk_dlt) && equal_flag_out == $past(chk_deq))
      else $error("double compare less or equal wrong");
   a_flag_hold: assert property (!any_op |=> $stable({zero_result_flag_out,
      negative_result_flag_out, less_than_flag_out, equal_flag_out,
      greater_than_flag_out}) && !done_out)
      else $error("flags changed with no instruction");
   a_xor_keeps_cmp: assert property (xor_go |=>
      $stable({less_than_flag_out, equal_flag_out, greater_than_flag_out}))
      else $error("xor changed compare flags");
   a_cmp_keeps_xor: assert property (cmp_go |=>
      $stable({zero_result_flag_out, negative_result_flag_out}) && done_out && !reject_out)
      else $error("compare changed xor flags");
   a_cmp_unsigned: assert property (is_cd && acc_out[`ACU_MSB] && !use_imm_in &&
      !mem_word_hi_in[WORD_W-1] |=> greater_than_flag_out)
      else $error("compare not unsigned");

   c_xor_double: cover property (is_xd ##1 zero_result_flag_out);
   c_xor_fmt: cover property (xf_go && bit_count_in == `ACU_CNT_MAX);
   c_cmp_word_lt: cover property (is_cw ##1 less_than_flag_out);
   c_fmt_refused: cover property (xf_bad ##1 reject_out);
   c_cmp_double_eq: cover property (is_cd ##1 equal_flag_out);
endmodule

/* File: acu_mem_model.sv */
// operand memory model standing in for the sequencer's data side
`timescale 1ns/1ns
module acu_mem_model (
   input wire logic clk_sys_in,
   input wire logic wr_en_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wr_data_in,
   input wire logic rd_en_in,
   output logic [15:0] word_lo_out,
   output logic [15:0] word_hi_out,
   output logic [31:0] bit_run_out
);
   logic [15:0] mem [0:15];
   logic [31:0] pair;
   always_ff @(posedge clk_sys_in) begin
      if (wr_en_in) begin
         mem[addr_in] <= wr_data_in;
      end
   end
   // high word comes from the following address
   assign pair = {mem[addr_in + 4'h1], mem[addr_in]};
   // outside a read the lines show inverted data, never a stale copy
   assign word_lo_out = rd_en_in ? pair[15:0] : ~pair[15:0];
   assign word_hi_out = rd_en_in ? pair[31:16] : ~pair[31:16];
   // gathered bits arrive unmasked above the run length
   assign bit_run_out = rd_en_in ? pair : ~pair;
endmodule

/* File: tb_acu_xor_compare_unit.sv */
// self-checking bench for the accumulator xor and compare unit
`timescale 1ns/1ns
module tb_acu_xor_compare_unit;
   import acu_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, ld = 1'b0, vld = 1'b0, ui = 1'b0, wr = 1'b0, rd = 1'b0;
   acu_op_e opc = acu_xor_double_op;
   logic [31:0] ld_d = 32'h0, imm = 32'h0, run, acc, ea = 32'h0;
   logic [15:0] lo, hi, wd = 16'h0;
   logic [15:0] sh [0:15];
   logic [3:0] addr = 4'h0;
   logic [2:0] sp = 3'h0;
   logic [5:0] cnt = 6'h1;
   logic z, ng, lt, eq, gt, done, rej;
   logic [4:0] ef = 5'h0;
   int miscompares = 0;
   int n_compared = 0;
   always #50 clk = ~clk;
   acu_mem_model mem (.clk_sys_in(clk), .wr_en_in(wr), .addr_in(addr), .wr_data_in(wd),
      .rd_en_in(rd), .word_lo_out(lo), .word_hi_out(hi), .bit_run_out(run));
   acu_xor_compare_unit dut (.clk_sys_in(clk), .reset_n_in(rst_n), .acc_load_in(ld),
      .acc_load_data_in(ld_d), .op_valid_in(vld), .op_code_in(opc), .use_imm_in(ui),
      .imm_in(imm), .mem_word_lo_in(lo), .mem_word_hi_in(hi), .bit_space_in(sp),
      .bit_count_in(cnt), .bit_run_in(run), .acc_out(acc), .zero_result_flag_out(z),
      .negative_result_flag_out(ng), .less_than_flag_out(lt), .equal_flag_out(eq),
      .greater_than_flag_out(gt), .done_out(done), .reject_out(rej));
   // ---------------------------------------------
   // compare and closing
   // ---------------------------------------------
   task chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_of_test;
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // access tasks
   // ---------------------------------------------
   task put(logic [3:0] a, logic [15:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wd = d;
      sh[a] = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task load(logic [31:0] d);
      @(negedge clk);
      ld = 1'b1;
      ld_d = d;
      @(negedge clk);
      ld = 1'b0;
      ea = d;
      chk("acc", ea, acc);
   endtask
   task op(acu_op_e c, logic [31:0] v, logic [2:0] s, logic [5:0] n, logic [3:0] a, logic u);
      logic [31:0] b;
      logic [31:0] x;
      logic ok;
      @(negedge clk);
      opc = c;
      imm = v;
      sp = s;
      cnt = n;
      addr = a;
      ui = u;
      vld = 1'b1;
      rd = 1'b1;
      ok = (c != acu_xor_formatted_op) || (s != 3'h7 && n != 6'h0 && n <= 6'h20);
      b = {sh[a + 4'h1], sh[a]};
      if (c == acu_compare_word_op) b = {16'h0, b[15:0]};
      if (c == acu_xor_formatted_op) b = b & (32'hffff_ffff >> (32 - n));
      if (u || c == acu_xor_double_op) b = v;
      if (c == acu_xor_double_op || (c == acu_xor_formatted_op && ok)) begin
         ea = ea ^ b;
         ef[4:3] = {ea == 32'h0, ea[31]};
      end
      if (c == acu_compare_word_op || c == acu_compare_double_op) begin
         x = (c == acu_compare_word_op) ? {16'h0, ea[15:0]} : ea;
         ef[2:0] = {x < b, x == b, x > b};
      end
      @(negedge clk);
      vld = 1'b0;
      rd = 1'b0;
      chk("acc", ea, acc);
      chk("flags", {27'h0, ef}, {27'h0, z, ng, lt, eq, gt});
      chk("done_reject", {30'h0, ok, !ok}, {30'h0, done, rej});
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      chk("acc", 32'h0, acc);
      chk("flags", 32'h0, {27'h0, z, ng, lt, eq, gt});
      chk("done_reject", 32'h0, {30'h0, done, rej});
      put(4'h0, 16'h0005);
      put(4'h1, 16'h8000);
      put(4'h2, 16'hfff6);
      put(4'h3, 16'h0003);
      load(32'h8000_0001);
      op(acu_xor_double_op, 32'h8000_0001, 3'h0, 6'h1, 4'h0, 1'b1);
      op(acu_xor_double_op, 32'hffff_0000, 3'h0, 6'h1, 4'h0, 1'b1);
      for (int s = 0; s < 7; s++) begin
         op(acu_xor_formatted_op, 32'h0, s[2:0], 6'(s * 5 + 1), 4'h2, 1'b0);
      end
      op(acu_xor_formatted_op, 32'h0, 3'h7, 6'h4, 4'h2, 1'b0);
      op(acu_xor_formatted_op, 32'h0, 3'h1, 6'h0, 4'h2, 1'b0);
      op(acu_xor_formatted_op, 32'h0, 3'h1, 6'h21, 4'h2, 1'b0);
      load(32'h0003_fff6);
      op(acu_xor_formatted_op, 32'h0, 3'h2, 6'h20, 4'h2, 1'b0);
      op(acu_xor_formatted_op, 32'h0, 3'h6, 6'h20, 4'h0, 1'b0);
      op(acu_compare_word_op, 32'h0, 3'h0, 6'h1, 4'h0, 1'b0);
      op(acu_compare_word_op, 32'h0, 3'h0, 6'h1, 4'h2, 1'b0);
      op(acu_compare_word_op, 32'h0, 3'h0, 6'h1, 4'h3, 1'b0);
      op(acu_compare_double_op, 32'h7fff_ffff, 3'h0, 6'h1, 4'h0, 1'b1);
      op(acu_compare_double_op, 32'h8000_0005, 3'h0, 6'h1, 4'h0, 1'b1);
      op(acu_compare_double_op, 32'h0, 3'h0, 6'h1, 4'h0, 1'b0);
      op(acu_compare_double_op, 32'h0, 3'h0, 6'h1, 4'h1, 1'b0);
      op(acu_compare_double_op, 32'h0, 3'h0, 6'h1, 4'h2, 1'b0);
      op(acu_xor_double_op, 32'h0000_0005, 3'h0, 6'h1, 4'h0, 1'b0);
      // reset again in mid-run: all state clears, memory keeps its words
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      ea = 32'h0;
      ef = 5'h0;
      chk("acc", ea, acc);
      chk("flags", {27'h0, ef}, {27'h0, z, ng, lt, eq, gt});
      chk("done_reject", 32'h0, {30'h0, done, rej});
      op(acu_xor_formatted_op, 32'h0, 3'h1, 6'h10, 4'h0, 1'b0);
      end_of_test;
   end
   initial begin
      #1000000;
      miscompares++;
      end_of_test;
   end
endmodule
